// >>> design/hsp_sideband.sv
// Design decisions made here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module hsp_sideband
  import hsp_pkg::*;
#(
  parameter logic [31:0] ID_VALUE = 32'h0000_5a01 // arbitrary value
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        upstream_power_sense,
  input  wire logic        local_power_present,
  input  wire logic        config_method_strap_0,
  input  wire logic        config_method_strap_1,
  input  wire logic        fixed_device_strap_0,
  input  wire logic        fixed_device_strap_1,
  input  wire logic [1:0]  port_charging_strap,
  input  wire logic [1:0]  port_overcurrent_n,
  input  wire logic [1:0]  port_pin_in,
  output logic [1:0]       port_pin_out,
  output logic [1:0]       port_pin_oe,
  output logic             suspend_wake_out,
  output logic             suspend_wake_oe,
  output logic             high_speed_indicator,
  output logic             upstream_reconnect,
  output logic [1:0]       config_method,
  output logic [1:0]       fixed_device_ports,
  output logic [1:0]       port_charging_en,
  output logic             irq
);
  localparam int unsigned SW = 8;

  logic [SW-1:0] raw_s, syn_s;
  logic          up_pwr, local_s, cfg0_s, cfg1_s, fix0_s, fix1_s;
  logic [1:0]    bc_s, ocs_n_s, pin_s;
  logic [31:0]   ctrl_q;
  hsp_phase_t    phase_q;
  logic          local_q, hs_pol_q;
  logic          up_pwr_q;
  logic [1:0]    oc_q;
  logic [IRQ_W-1:0] ist_q, imask_q, iset;
  logic          aw_q, w_q;
  logic [7:0]    awaddr_q;
  logic [31:0]   wdata_q;
  logic [3:0]    wstrb_q;
  logic [1:0]    comb, pwr, pin_ok;
  logic [3:0]    rel_q;
  logic          wake_q;

  assign raw_s = {port_overcurrent_n, config_method_strap_1,
                  config_method_strap_0, fixed_device_strap_1,
                  fixed_device_strap_0, local_power_present,
                  upstream_power_sense};

  hsp_sync #(.W(SW), .INIT({2'b11, 6'h00})) u_sync_a (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       (raw_s),
    .q       (syn_s)
  );

  hsp_sync #(.W(4), .INIT(4'hf)) u_sync_b (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       ({port_pin_in, port_charging_strap}),
    .q       ({pin_s, bc_s})
  );

  assign up_pwr  = syn_s[0];
  assign local_s = syn_s[1];
  assign fix0_s  = syn_s[2];
  assign fix1_s  = syn_s[3];
  assign cfg0_s  = syn_s[4];
  assign cfg1_s  = syn_s[5];
  assign ocs_n_s = syn_s[7:6];

  assign comb = ctrl_q[CTRL_COMB_LSB +: NUM_PORTS];
  assign pwr  = ctrl_q[CTRL_PWR_LSB +: NUM_PORTS];

  // waits three cycles after release so the synchronisers carry pin levels
  logic [1:0] settle_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_q  <= HSP_IDLE;
      settle_q <= 2'h0;
    end else begin
      unique case (phase_q)
        HSP_IDLE: begin
          settle_q <= settle_q + 2'h1;
          if (settle_q == SETTLE_LAST) phase_q <= HSP_SAMPLE;
        end
        HSP_SAMPLE: phase_q <= HSP_RUN;
        HSP_RUN:    phase_q <= HSP_RUN;
      endcase
    end
  end

  // straps and local power caught once after release, held to next reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      local_q            <= 1'b0;
      hs_pol_q           <= 1'b0;
      config_method      <= 2'h0;
      fixed_device_ports <= 2'h0;
      port_charging_en   <= 2'h0;
    end else if (phase_q == HSP_SAMPLE) begin
      local_q            <= local_s;
      hs_pol_q           <= cfg1_s;
      config_method      <= {cfg1_s, cfg0_s};
      fixed_device_ports <= {fix1_s, fix0_s};
      port_charging_en   <= bc_s;
    end
  end

  // over-current: dedicated input, or combined pin only while released
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      oc_q <= 2'h0;
    end else begin
      for (int i = 0; i < NUM_PORTS; i++) begin
        if (comb[i]) begin
          if (pin_ok[i]) oc_q[i] <= ~pin_s[i];
        end else begin
          oc_q[i] <= ~ocs_n_s[i];
        end
      end
    end
  end

  // pins: combined mode is open drain, released to enable power
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_pin_out <= 2'h0;
      port_pin_oe  <= 2'h0;
      rel_q        <= 4'h0;
    end else begin
      rel_q        <= {rel_q[1:0], comb & ~port_pin_oe};
      for (int i = 0; i < NUM_PORTS; i++) begin
        if (comb[i]) begin
          port_pin_out[i] <= 1'b0;
          port_pin_oe[i]  <= ~pwr[i];
        end else begin
          port_pin_out[i] <= pwr[i];
          port_pin_oe[i]  <= 1'b1;
        end
      end
    end
  end

  // pin_s lags oe by the synchroniser, so a pin still pulled low is not seen
  assign pin_ok = comb & rel_q[3:2];

  // upstream power: a drop, not a return, restarts the link, not the device
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      up_pwr_q           <= 1'b0;
      upstream_reconnect <= 1'b0;
    end else begin
      up_pwr_q           <= up_pwr;
      upstream_reconnect <= up_pwr_q & ~up_pwr;
    end
  end

  // wake mode drives low for one cycle per event; suspend mode shows state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      suspend_wake_out <= 1'b0;
      suspend_wake_oe  <= 1'b1;
      wake_q           <= 1'b0;
    end else begin
      suspend_wake_out <= 1'b0;
      wake_q           <= ctrl_q[CTRL_WAKE_EV];
      if (ctrl_q[CTRL_WAKE_MD]) begin
        suspend_wake_oe <= ctrl_q[CTRL_WAKE_EV] & ~wake_q;
      end else begin
        suspend_wake_oe <= ~(ctrl_q[CTRL_CONFIG]
                             & ~ctrl_q[CTRL_SUSP]);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      high_speed_indicator <= 1'b0;
    end else begin
      high_speed_indicator <= ctrl_q[CTRL_HS] ^ hs_pol_q;
    end
  end

  // interrupt events
  always_comb begin
    iset = '0;
    iset[IRQ_PWR_ON]  = up_pwr & ~up_pwr_q;
    iset[IRQ_PWR_OFF] = up_pwr_q & ~up_pwr;
    for (int i = 0; i < NUM_PORTS; i++) begin
      iset[IRQ_OC_LSB + i] = ~oc_q[i] & ((pin_ok[i] & ~pin_s[i])
                             | (~comb[i] & ~ocs_n_s[i]));
    end
  end

  // axi-lite write path
  logic wr_go;
  assign wr_go = aw_q & w_q & ~s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q     <= 1'b0;
      w_q      <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_q     <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_q <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_q     <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end else if (wr_go) begin
        w_q <= 1'b0;
      end
    end
  end

  assign s_axi_awready = ~aw_q;
  assign s_axi_wready  = ~w_q;

  function automatic logic [31:0] apply_strb(logic [31:0] old,
                                             logic [31:0] nw,
                                             logic [3:0]  st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) if (st[b]) r[8*b +: 8] = nw[8*b +: 8];
    return r;
  endfunction

  function automatic logic addr_ok(logic [7:0] a);
    return a == OFS_CTRL || a == OFS_STATUS || a == OFS_STRAPS ||
           a == OFS_IRQ_ST || a == OFS_IRQ_MK || a == OFS_ID;
  endfunction

  logic [31:0] wmask, imask_wr;
  assign wmask = apply_strb(32'h0, 32'hffff_ffff, wstrb_q);
  assign imask_wr = apply_strb({28'h0, imask_q}, wdata_q, wstrb_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q  <= CTRL_RESET;
      imask_q <= '0;
      ist_q   <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else begin
      // set wins over a write-one clear in the same cycle
      ist_q <= (ist_q & ~((wr_go && awaddr_q == OFS_IRQ_ST)
                          ? wdata_q[IRQ_W-1:0] & wmask[IRQ_W-1:0]
                          : '0)) | iset;
      if (wr_go && awaddr_q == OFS_CTRL) begin
        ctrl_q <= apply_strb(ctrl_q, wdata_q, wstrb_q);
      end
      if (wr_go && awaddr_q == OFS_IRQ_MK) begin
        imask_q <= imask_wr[IRQ_W-1:0];
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= addr_ok(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) irq <= 1'b0;
    else          irq <= |(ist_q & imask_q);
  end

  // axi-lite read path
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid & s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= addr_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      unique case (s_axi_araddr)
        OFS_CTRL:   s_axi_rdata <= ctrl_q;
        OFS_STATUS: s_axi_rdata <= {27'h0, phase_q == HSP_RUN,
                                    oc_q, local_q, up_pwr_q};
        OFS_STRAPS: s_axi_rdata <= {26'h0, port_charging_en,
                                    fixed_device_ports, config_method};
        OFS_IRQ_ST: s_axi_rdata <= {28'h0, ist_q};
        OFS_IRQ_MK: s_axi_rdata <= {28'h0, imask_q};
        OFS_ID:     s_axi_rdata <= ID_VALUE;
        default:    s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  assign s_axi_arready = ~s_axi_rvalid;

  a_reconnect_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
    (up_pwr_q & ~up_pwr) |=> upstream_reconnect ##1 !upstream_reconnect)
    else $error("reconnect pulse missing");
  a_hs_polarity: assert property (@(posedge aclk) disable iff (!aresetn)
    high_speed_indicator == ($past(ctrl_q[CTRL_HS]) ^ $past(hs_pol_q)))
    else $error("high-speed indicator wrong");
  a_susp_active: assert property (@(posedge aclk) disable iff (!aresetn)
    (!ctrl_q[CTRL_WAKE_MD] && ctrl_q[CTRL_CONFIG] && !ctrl_q[CTRL_SUSP])
    |=> !suspend_wake_oe) else $error("suspend pin not released");
  a_straps_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (phase_q == HSP_RUN) |=> $stable(config_method) && $stable(local_q))
    else $error("strap changed after latch");
  a_comb_release: assert property (@(posedge aclk) disable iff (!aresetn)
    (comb[0] && pwr[0]) |=> !port_pin_oe[0])
    else $error("combined pin driven while enabled");
  a_port_power: assert property (@(posedge aclk) disable iff (!aresetn)
    (!comb[1]) |=> port_pin_oe[1] && port_pin_out[1] == $past(pwr[1]))
    else $error("port power output wrong");
  a_oc_low: assert property (@(posedge aclk) disable iff (!aresetn)
    (!comb[0] && !ocs_n_s[0]) |=> oc_q[0])
    else $error("overcurrent not flagged");
  a_local_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (phase_q == HSP_SAMPLE) |=> local_q == $past(local_s))
    else $error("local power not latched");
  a_up_power: assert property (@(posedge aclk) disable iff (!aresetn)
    up_pwr_q == $past(up_pwr)) else $error("power sense lost");
endmodule
`default_nettype wire

// >>> design/hsp_sync.sv
`timescale 1ns/1ps
`default_nettype none
// two-flop synchroniser bank for pin inputs
module hsp_sync #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= INIT;
      q      <= INIT;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule
`default_nettype wire

// >>> inc/hsp_pkg.sv
`default_nettype none
package hsp_pkg;
  localparam int unsigned CLK_MHZ        = 100;
  localparam int unsigned EXT_RST_MIN_US = 5;
  localparam int unsigned EXT_RST_CYC    = EXT_RST_MIN_US * CLK_MHZ;
  localparam int unsigned NUM_PORTS      = 2;
  // last count of the post-reset wait before straps are caught
  localparam logic [1:0]  SETTLE_LAST    = 2'h2;

  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_STRAPS = 8'h08;
  localparam logic [7:0] OFS_IRQ_ST = 8'h0c;
  localparam logic [7:0] OFS_IRQ_MK = 8'h10;
  localparam logic [7:0] OFS_ID     = 8'h14;

  // ctrl fields
  localparam int unsigned CTRL_PWR_LSB  = 0;
  localparam int unsigned CTRL_COMB_LSB = 2;
  localparam int unsigned CTRL_WAKE_MD  = 4;
  localparam int unsigned CTRL_CONFIG   = 5;
  localparam int unsigned CTRL_SUSP     = 6;
  localparam int unsigned CTRL_HS       = 7;
  localparam int unsigned CTRL_WAKE_EV  = 8;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;

  // status fields
  localparam int unsigned ST_UP_PWR = 0;
  localparam int unsigned ST_LOCAL  = 1;
  localparam int unsigned ST_OC_LSB = 2;
  localparam int unsigned ST_RENEG  = 4;

  // strap fields
  localparam int unsigned SP_CFG_LSB = 0;
  localparam int unsigned SP_FIX_LSB = 2;
  localparam int unsigned SP_BC_LSB  = 4;

  // interrupt bits
  localparam int unsigned IRQ_PWR_ON  = 0;
  localparam int unsigned IRQ_PWR_OFF = 1;
  localparam int unsigned IRQ_OC_LSB  = 2;
  localparam int unsigned IRQ_W       = 4;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {HSP_IDLE, HSP_SAMPLE, HSP_RUN} hsp_phase_t;
endpackage
`default_nettype wire

// >>> tb/hsp_board.sv
`timescale 1ns/1ps
`default_nettype none
// board around the hub: pulled-up port pins, current monitors, indicator
module hsp_board (
  input  wire logic [1:0] pin_out,
  input  wire logic [1:0] pin_oe,
  input  wire logic [1:0] shared,
  input  wire logic [1:0] fault,
  input  wire logic       ind_out,
  input  wire logic       ind_oe,
  output logic      [1:0] pin_level,
  output logic      [1:0] ocn,
  output logic            ind_level
);
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      // monitor sinks the shared pin on a fault, pull-up otherwise
      pin_level[i] = (pin_oe[i] ? pin_out[i] : 1'b1) & ~(shared[i] & fault[i]);
      ocn[i] = ~(fault[i] & ~shared[i]); // monitor pulls low on a fault of an unshared pin
    end
    ind_level = ~(ind_oe & ~ind_out); // pulled up unless sunk
  end
endmodule
`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import hsp_pkg::*;
  localparam logic [31:0] TB_ID = 32'h0000_1234; // arbitrary value
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic        upstream_power_sense = 1'b0, local_power_present = 1'b1;
  logic        config_method_strap_0 = 1'b1, config_method_strap_1 = 1'b0;
  logic        fixed_device_strap_0 = 1'b0, fixed_device_strap_1 = 1'b1;
  logic [1:0]  port_charging_strap = 2'h1, shared = 2'h0, fault = 2'h0;
  logic [1:0]  port_overcurrent_n, port_pin_in, port_pin_out, port_pin_oe;
  logic [1:0]  config_method, fixed_device_ports, port_charging_en;
  logic        suspend_wake_out, suspend_wake_oe, high_speed_indicator;
  logic        upstream_reconnect, irq, ind_level;
  int          err_total = 0, n_tests = 0, n_reconn = 0, n_low = 0, low0;

  hsp_sideband #(.ID_VALUE(TB_ID)) i_dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .upstream_power_sense, .local_power_present, .config_method_strap_0,
    .config_method_strap_1, .fixed_device_strap_0, .fixed_device_strap_1,
    .port_charging_strap, .port_overcurrent_n, .port_pin_in, .port_pin_out,
    .port_pin_oe, .suspend_wake_out, .suspend_wake_oe, .high_speed_indicator,
    .upstream_reconnect, .config_method, .fixed_device_ports,
    .port_charging_en, .irq
  );
  hsp_board i_board (
    .pin_out(port_pin_out), .pin_oe(port_pin_oe), .shared(shared),
    .fault(fault), .ind_out(suspend_wake_out), .ind_oe(suspend_wake_oe),
    .pin_level(port_pin_in), .ocn(port_overcurrent_n), .ind_level(ind_level)
  );

  always #5 aclk = ~aclk;
  always @(posedge aclk) begin
    if (upstream_reconnect === 1'b1) n_reconn <= n_reconn + 1;
    if (ind_level === 1'b0) n_low <= n_low + 1;
  end

  function automatic logic [31:0] straps_exp();
    return ({30'h0, config_method_strap_1, config_method_strap_0}
              << SP_CFG_LSB)
         | ({30'h0, fixed_device_strap_1, fixed_device_strap_0} << SP_FIX_LSB)
         | ({30'h0, port_charging_strap} << SP_BC_LSB);
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    if (err_total == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // handshakes are judged at the falling edge, where nothing is moving
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok, w_ok, b_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    b_ok = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!b_ok) begin
      @(negedge aclk);
      aw_ok = aw_ok | (s_axi_awvalid & s_axi_awready);
      w_ok = w_ok | (s_axi_wvalid & s_axi_wready);
      b_ok = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge aclk);
      if (aw_ok) s_axi_awvalid <= 1'b0;
      if (w_ok) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    logic ar_ok, r_ok;
    ar_ok = 1'b0;
    r_ok = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!r_ok) begin
      @(negedge aclk);
      ar_ok = ar_ok | (s_axi_arvalid & s_axi_arready);
      r_ok = s_axi_rvalid;
      rd = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge aclk);
      if (ar_ok) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    rd_reg(a);
    chk(rd, exp);
  endtask
  task automatic do_reset(input int n);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (n) @(posedge aclk);
    aresetn <= 1'b1;
    tick(6);
  endtask

  initial begin
    #300000;
    err_total++;
    end_sim();
  end

  initial begin
    do_reset(12);
    rchk(OFS_CTRL, CTRL_RESET);
    rchk(OFS_ID, TB_ID);
    rchk(OFS_STRAPS, straps_exp());
    chk({config_method, fixed_device_ports, port_charging_en}, 6'h19);
    local_power_present <= 1'b0;
    tick(4);
    rd_reg(OFS_STATUS);
    chk(rd[ST_LOCAL], 1'b1);
    chk(rd[ST_UP_PWR], 1'b0);
    chk(ind_level, 1'b0);
    chk(high_speed_indicator, 1'b0);
    wr(OFS_IRQ_MK, 32'h0000_000f);
    // configured, high speed, port 1 powered
    wr(OFS_CTRL, 32'h0000_00a1);
    tick(3);
    chk(ind_level, 1'b1);
    chk(high_speed_indicator, 1'b1);
    chk(port_pin_in, 2'h1);
    // suspended, port 2 powered
    wr(OFS_CTRL, 32'h0000_00e2);
    tick(3);
    chk(ind_level, 1'b0);
    chk(port_pin_in, 2'h2);
    wr(OFS_CTRL, 32'h0000_0032);
    tick(3);
    low0 = n_low;
    wr(OFS_CTRL, 32'h0000_0132);
    tick(4);
    chk(n_low - low0, 1);
    upstream_power_sense <= 1'b1;
    tick(5);
    chk(irq, 1'b1);
    rchk(OFS_IRQ_ST, 32'h0000_0001);
    wr(OFS_IRQ_ST, 32'h0000_0001);
    tick(2);
    chk(irq, 1'b0);
    upstream_power_sense <= 1'b0;
    tick(6);
    chk(n_reconn, 1);
    rchk(OFS_IRQ_ST, 32'h0000_0002);
    rchk(OFS_CTRL, 32'h0000_0132);
    wr(OFS_IRQ_ST, 32'h0000_000f);
    fault <= 2'h3;
    tick(5);
    rd_reg(OFS_STATUS);
    chk(rd[3:2], 2'h3);
    rchk(OFS_IRQ_ST, 32'h0000_000c);
    fault <= 2'h0;
    shared <= 2'h3;
    wr(OFS_IRQ_ST, 32'h0000_000f);
    // both ports combined, only port 1 powered
    wr(OFS_CTRL, 32'h0000_002d);
    tick(3);
    chk(port_pin_oe, 2'h2);
    chk(port_pin_in, 2'h1);
    rchk(OFS_IRQ_ST, 32'h0000_0000);
    fault <= 2'h1;
    tick(5);
    rd_reg(OFS_STATUS);
    chk(rd[ST_OC_LSB], 1'b1);
    fault <= 2'h0;
    rd_reg(8'h20);
    chk(resp, RESP_SLVERR);
    chk(rd, 32'h0);
    wr(8'h20, 32'hffff_ffff);
    chk(resp, RESP_SLVERR);
    config_method_strap_1 <= 1'b1;
    config_method_strap_0 <= 1'b0;
    fixed_device_strap_0 <= 1'b1;
    port_charging_strap <= 2'h2;
    tick(4);
    rchk(OFS_STRAPS, 32'h0000_0019);
    do_reset(EXT_RST_CYC);
    rchk(OFS_STRAPS, straps_exp());
    rd_reg(OFS_STATUS);
    chk(rd[ST_LOCAL], 1'b0);
    chk(high_speed_indicator, 1'b1);
    wr(OFS_CTRL, 32'h0000_0080);
    tick(3);
    chk(high_speed_indicator, 1'b0);
    end_sim();
  end
endmodule
`default_nettype wire
